// File: branch_bit_control_decoder.sv
// decode and execute of branches, bit ops, control and far jump/call
// assumes program and data memories with combinational reads and clocked writes
`include "bbc_decoder_defs.svh"
module branch_bit_control_decoder
    import bbc_decoder_pkg::*;
(
    // clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    // program memory
    output logic [11:0]      o_prog_addr,
    input  wire logic [7:0]  i_prog_data,
    // data space
    output logic [7:0]       o_data_addr,
    output logic             o_data_we,
    output logic [7:0]       o_data_wdata,
    input  wire logic [7:0]  i_data_rdata,
    // core context
    input  wire logic        i_watchdog_sel,
    input  wire logic        i_wake,
    input  wire logic [11:0] i_ret_addr,
    input  wire logic        i_saved_zero,
    input  wire logic        i_saved_carry,
    // status and side effects
    output logic             o_zero,
    output logic             o_carry,
    output logic             o_push,
    output logic             o_pop,
    output logic             o_int_done,
    output logic             o_stop,
    output logic             o_waiting,
    output logic             o_other_op,
    output logic             o_index_sel,
    output logic [11:0]      o_pc
);
    // sequencing and instruction registers
    exec_state_t state_reg;
    op_class_t   op_reg;
    logic [7:0]  opc_reg;
    logic [7:0]  opnd_reg;
    logic [7:0]  disp_reg;
    logic [2:0]  cyc_reg;
    logic [11:0] pc_reg;
    logic [11:0] inst_pc_reg;
    logic        zero_reg;
    logic        carry_reg;

    // decode helpers
    op_class_t   fetch_op;
    logic        tbit;
    logic        last_cyc;
    logic        branch_taken;

    // opcode class from the byte map; anything unlisted leaves the block
    function automatic op_class_t classify(input logic [7:0] opc);
        op_class_t c;
        unique case (opc[3:0])
            4'h0, 4'h8: c = OP_BR_ZC;
            4'h2, 4'hA: c = OP_BR_CC;
            4'h4, 4'hC: c = OP_BR_ZS;
            4'h6, 4'hE: c = OP_BR_CS;
            4'h1:       c = OP_CALL;
            4'h9:       c = OP_JUMP;
            4'h3:       c = OP_BIT_TEST;
            4'hB:       c = opc[4] ? OP_BIT_SET : OP_BIT_CLR;
            4'hD:       c = OP_IDLE;
            default:    c = OP_OTHER;
        endcase
        unique case (opc)
            `OPC_IDLE:     c = OP_IDLE;
            `OPC_SUB_EXIT: c = OP_SUB_EXIT;
            `OPC_INT_EXIT: c = OP_INT_EXIT;
            `OPC_WAIT:     c = OP_WAIT;
            `OPC_STOP:     c = OP_STOP;
            default: ;
        endcase
        return c;
    endfunction

    // cycles an instruction takes, fetch included
    function automatic logic [2:0] op_cycles(input op_class_t op);
        logic [2:0] n;
        unique case (op)
            OP_BIT_TEST:                               n = `CYC_BITTEST;
            OP_CALL, OP_JUMP, OP_BIT_SET, OP_BIT_CLR: n = `CYC_LONG;
            default:                                   n = `CYC_SHORT;
        endcase
        return n;
    endfunction

    // short branch: opcode bit 3 backward, high nibble span; -15..+16
    function automatic logic [11:0] short_target(input logic [11:0] pc, input logic [7:0] opc);
        logic [11:0] span;
        span = {8'h00, opc[7:4]};
        if (opc[3])
            return pc - span;
        return pc + span + 12'd1;
    endfunction

    // condition of the four short branches
    function automatic logic branch_cond(input op_class_t op, input logic z, input logic c);
        logic t;
        unique case (op)
            OP_BR_CS: t = c;
            OP_BR_CC: t = !c;
            OP_BR_ZS: t = z;
            OP_BR_ZC: t = !z;
            default:  t = 1'b0;
        endcase
        return t;
    endfunction

    assign fetch_op     = classify(i_prog_data);
    assign tbit         = i_data_rdata[opc_reg[7:5]];
    assign last_cyc     = (state_reg == ST_EXEC) && (cyc_reg == op_cycles(op_reg) - 3'd1);
    assign branch_taken = branch_cond(op_reg, zero_reg, carry_reg);

    // sequencing: one state step and one cycle count per clock
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            state_reg <= ST_FETCH;
            cyc_reg   <= 3'd0;
        end else begin
            cyc_reg <= (state_reg == ST_FETCH) ? 3'd1 : cyc_reg + 3'd1;
            unique case (state_reg)
                ST_FETCH: begin
                    unique case (fetch_op)
                        OP_CALL, OP_JUMP, OP_BIT_TEST, OP_BIT_SET, OP_BIT_CLR: state_reg <= ST_OPND;
                        default: state_reg <= ST_EXEC;
                    endcase
                end
                ST_OPND: begin
                    if (op_reg == OP_BIT_TEST)
                        state_reg <= ST_DISP;
                    else if (op_reg == OP_CALL || op_reg == OP_JUMP)
                        state_reg <= ST_EXEC;
                    else
                        state_reg <= ST_READ;
                end
                ST_DISP: state_reg <= ST_READ;
                ST_READ: state_reg <= ST_EXEC;
                ST_EXEC: begin
                    if (last_cyc) begin
                        if (op_reg == OP_WAIT || op_reg == OP_STOP)
                            state_reg <= ST_WAIT;
                        else
                            state_reg <= ST_FETCH;
                    end
                end
                ST_WAIT: begin
                    if (i_wake)
                        state_reg <= ST_FETCH;
                end
                default: state_reg <= ST_FETCH;
            endcase
        end
    end

    // instruction bytes captured as they stream in
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            op_reg   <= OP_IDLE;
            opc_reg  <= 8'h00;
            opnd_reg <= 8'h00;
            disp_reg <= 8'h00;
        end else begin
            if (state_reg == ST_FETCH) begin
                opc_reg <= i_prog_data;
                op_reg  <= fetch_op;
            end
            if (state_reg == ST_OPND)
                opnd_reg <= i_prog_data;
            if (state_reg == ST_DISP)
                disp_reg <= i_prog_data;
        end
    end

    // program counter: one step per byte fetched, load on a taken transfer
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            pc_reg      <= `PC_RESET;
            inst_pc_reg <= `PC_RESET;
        end else begin
            unique case (state_reg)
                ST_FETCH: begin
                    inst_pc_reg <= pc_reg;
                    pc_reg      <= pc_reg + 12'd1;
                end
                ST_OPND, ST_DISP: pc_reg <= pc_reg + 12'd1;
                ST_EXEC: begin
                    if (last_cyc) begin
                        unique case (op_reg)
                            OP_BR_CS, OP_BR_CC, OP_BR_ZS, OP_BR_ZC: begin
                                if (branch_taken)
                                    pc_reg <= short_target(inst_pc_reg, opc_reg);
                            end
                            OP_CALL, OP_JUMP: pc_reg <= {opc_reg[7:4], opnd_reg};
                            OP_BIT_TEST: begin
                                if (tbit == opc_reg[4])
                                    pc_reg <= inst_pc_reg + 12'd2 + {{4{disp_reg[7]}}, disp_reg};
                            end
                            OP_SUB_EXIT, OP_INT_EXIT: pc_reg <= i_ret_addr;
                            default: ;
                        endcase
                    end
                end
                default: ;
            endcase
        end
    end

    // zero and carry: only bit test and interrupt exit touch them
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            zero_reg  <= 1'b0;
            carry_reg <= 1'b0;
        end else if (last_cyc) begin
            if (op_reg == OP_BIT_TEST)
                carry_reg <= tbit;
            if (op_reg == OP_INT_EXIT) begin
                zero_reg  <= i_saved_zero;
                carry_reg <= i_saved_carry;
            end
        end
    end

    // memory side: read-modify-write of one bit in the last cycle
    always_comb begin
        o_prog_addr  = pc_reg;
        o_data_addr  = opnd_reg;
        o_data_we    = 1'b0;
        o_data_wdata = i_data_rdata;
        if (last_cyc && (op_reg == OP_BIT_SET || op_reg == OP_BIT_CLR)) begin
            o_data_we                  = 1'b1;
            o_data_wdata[opc_reg[7:5]] = (op_reg == OP_BIT_SET);
        end
    end

    // status and stack strobes
    always_comb begin
        o_zero      = zero_reg;
        o_carry     = carry_reg;
        o_pc        = pc_reg;
        o_push      = last_cyc && op_reg == OP_CALL;
        o_pop       = last_cyc && (op_reg == OP_SUB_EXIT || op_reg == OP_INT_EXIT);
        o_int_done  = last_cyc && op_reg == OP_INT_EXIT;
        o_stop      = state_reg == ST_WAIT && op_reg == OP_STOP && !i_watchdog_sel;
        o_waiting   = state_reg == ST_WAIT;
        o_other_op  = state_reg == ST_EXEC && op_reg == OP_OTHER;
        o_index_sel = opc_reg[4];
    end
endmodule // branch_bit_control_decoder

// File: bbc_decoder_defs.svh
// constants for the branch, bit and control decoder
// assumes one core clock, synchronous low reset, byte-wide memory ports
// Contract
// - short branches on carry/zero set/clear; two cycles; flags kept
// - short offset is 5-bit signed, -15 to +16 from branch
// - bit-test branches: three bytes, five cycles, bit number and address
// - third byte is 8-bit signed displacement, -126 to +129
// - bit-test copies tested bit into carry; zero kept
// - bit set/clear any data byte; two bytes, four cycles; flags kept
// - idle, exits, wait, stop: one byte two cycles; interrupt exit restores flags
// - watchdog selected turns stop into wait
// - far jump and call: 12-bit target, two bytes, four cycles
// - low nibble 0,2,4,6 are short branches; 1 is call
// - low nibble 7 decodes loads, compares, adds, increment by high nibble; here it falls to OP_OTHER and raises o_other_op
// - opcode bit 4 picks index register for indirect access
`ifndef BBC_DECODER_DEFS_SVH
`define BBC_DECODER_DEFS_SVH
`define CYC_SHORT     3'd2
`define CYC_LONG      3'd4
`define CYC_BITTEST   3'd5
`define PC_RESET      12'h000
`define IDX_X_ADDR    8'h80
`define IDX_Y_ADDR    8'h81
`define OPC_IDLE      8'h04
`define OPC_SUB_EXIT  8'h0D
`define OPC_INT_EXIT  8'h4D
`define OPC_STOP      8'h6D
`define OPC_WAIT      8'hED
`endif

// File: bbc_decoder_pkg.sv
// types for the branch, bit and control decoder
// assumes the defs header is compiled alongside
package bbc_decoder_pkg;
    typedef enum logic [2:0] {
        ST_FETCH = 3'b000,
        ST_OPND  = 3'b001,
        ST_DISP  = 3'b011,
        ST_READ  = 3'b010,
        ST_EXEC  = 3'b110,
        ST_WAIT  = 3'b111
    } exec_state_t;
    typedef enum logic [3:0] {
        OP_IDLE, OP_BR_ZC, OP_BR_CC, OP_BR_ZS, OP_BR_CS, OP_CALL, OP_JUMP,
        OP_BIT_TEST, OP_BIT_SET, OP_BIT_CLR, OP_SUB_EXIT, OP_INT_EXIT,
        OP_WAIT, OP_STOP, OP_OTHER
    } op_class_t;
endpackage

// File: bbc_assertions.sv
// port checker for the branch, bit and control decoder
// assumes it is bound onto the decoder top module
module bbc_checker (
    input logic       i_ref_clk, i_rst_n, i_watchdog_sel, i_wake, o_data_we,
    input logic       o_zero, o_push, o_pop, o_int_done, o_stop, o_waiting,
    input logic [7:0] i_data_rdata, o_data_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_write; o_data_we; endsequence
    sequence s_wake; o_waiting && i_wake; endsequence
    property p_push_pulse; o_push |=> !o_push; endproperty
    a_push_pulse: assert property (p_push_pulse) else $error("push held");
    property p_write_once; s_write |=> !o_data_we; endproperty
    a_write_once: assert property (p_write_once) else $error("write held");
    property p_one_bit; s_write |-> $countones(o_data_wdata ^ i_data_rdata) <= 1; endproperty
    a_one_bit: assert property (p_one_bit) else $error("several bits changed");
    property p_write_alone; s_write |-> !o_push && !o_pop; endproperty
    a_write_alone: assert property (p_write_alone) else $error("stack move on write");
    property p_int_pops; o_int_done |-> o_pop; endproperty
    a_int_pops: assert property (p_int_pops) else $error("exit without pop");
    property p_stop_wd; o_stop |-> o_waiting && !i_watchdog_sel; endproperty
    a_stop_wd: assert property (p_stop_wd) else $error("stop with watchdog");
    property p_wake; s_wake |-> ##[1:3] !o_waiting; endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    property p_zero_kept; $changed(o_zero) |-> $past(o_int_done) || o_int_done; endproperty
    a_zero_kept: assert property (p_zero_kept) else $error("zero changed");
endmodule // bbc_checker
bind branch_bit_control_decoder bbc_checker u_bbc_checker (.i_ref_clk, .i_rst_n, .i_watchdog_sel, .i_wake,
    .o_data_we, .o_zero, .o_push, .o_pop, .o_int_done, .o_stop, .o_waiting, .i_data_rdata, .o_data_wdata);

// File: bbc_mem_model.sv
// program and data memory in front of the decoder
// assumes combinational reads and clocked writes
module bbc_mem_model (
    input  wire logic        i_ref_clk,
    input  wire logic [11:0] i_prog_addr,
    output logic      [7:0]  o_prog_data,
    input  wire logic [7:0]  i_data_addr,
    input  wire logic        i_data_we,
    input  wire logic [7:0]  i_data_wdata,
    output logic      [7:0]  o_data_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] prog_mem [4096];
    logic [7:0] data_mem [256];
    initial foreach (prog_mem[i]) prog_mem[i] = 8'h04;
    assign o_prog_data  = prog_mem[i_prog_addr];
    assign o_data_rdata = data_mem[i_data_addr];
    // plain bytes only: no port or odd-access registers here
    always @(posedge i_ref_clk) if (i_data_we) data_mem[i_data_addr] <= i_data_wdata;
endmodule // bbc_mem_model

// File: testbench.sv
// self-checking bench for the branch, bit and control decoder
// assumes checker and memory model compiled first
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_ref_clk = 0, i_rst_n = 0, i_watchdog_sel = 0, i_wake = 0, i_saved_zero = 0, i_saved_carry = 0;
    logic [11:0] i_ret_addr = 0, o_prog_addr, o_pc;
    logic [7:0]  i_prog_data, o_data_addr, o_data_wdata, i_data_rdata;
    logic        o_data_we, o_zero, o_carry, o_push, o_pop, o_int_done, o_stop, o_waiting, o_other_op, o_index_sel;
    int          errors = 0, n_tests = 0, cycles = 0;
    branch_bit_control_decoder u_branch_bit_control_decoder (.i_ref_clk, .i_rst_n, .o_prog_addr, .i_prog_data,
        .o_data_addr, .o_data_we, .o_data_wdata, .i_data_rdata, .i_watchdog_sel, .i_wake, .i_ret_addr, .i_saved_zero,
        .i_saved_carry, .o_zero, .o_carry, .o_push, .o_pop, .o_int_done, .o_stop, .o_waiting, .o_other_op,
        .o_index_sel, .o_pc);
    bbc_mem_model u_mem (.i_ref_clk, .i_prog_addr(o_prog_addr), .o_prog_data(i_prog_data), .i_data_addr(o_data_addr),
        .i_data_we(o_data_we), .i_data_wdata(o_data_wdata), .o_data_rdata(i_data_rdata));
    always #25 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            report_and_stop();
        end
    end
    task automatic step(input int n);
        repeat (n) @(posedge i_ref_clk);
        #2;
    endtask
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin : main
        int          kind, cyc, hi, bn;
        logic [11:0] base, ret2, exp_pc;
        logic [7:0]  op, b2, b3, dbyte, exp_d;
        logic        z, c, exp_c;
        void'($urandom(32'h7633_d2f2));
        #1;
        for (int t = 0; t < 48; t++) begin
            kind = t % 6;
            {op, b2, b3, dbyte} = $urandom;
            {z, c} = 2'($urandom);
            base = 12'h100 + 12'($urandom % 3584);
            ret2 = 12'($urandom);
            hi = op[7:4];
            bn = op[7:5];
            exp_c = c;
            exp_d = dbyte;
            cyc = 2;
            case (kind)
                0: begin
                    op[0] = 1'b0;
                    if (op == 8'h04) op[7:4] = 4'h1;
                    hi = op[7:4];
                    exp_pc = (op[2:1] == 0 ? !z : op[2:1] == 1 ? !c : op[2:1] == 2 ? z : c) ?
                             (op[3] ? base - 12'(hi) : base + 12'(hi) + 12'h001) : base + 12'h001;
                end
                1: begin
                    op[3:0] = op[3] ? 4'h9 : 4'h1;
                    exp_pc = {op[7:4], b2};
                    cyc = 4;
                end
                2: begin
                    op[3:0] = 4'h3;
                    exp_c = dbyte[bn];
                    exp_pc = (exp_c == op[4]) ? base + 12'h002 + {{4{b3[7]}}, b3} : base + 12'h003;
                    cyc = 5;
                end
                3: begin
                    op[3:0] = 4'hB;
                    exp_d[bn] = op[4];
                    exp_pc = base + 12'h002;
                    cyc = 4;
                end
                4: begin
                    op = op[0] ? 8'h0D : 8'h04;
                    exp_pc = op[0] ? ret2 : base + 12'h001;
                end
                default: op = op[0] ? 8'h6D : 8'hED;
            endcase
            u_mem.prog_mem[0] = 8'h4D;
            u_mem.prog_mem[base] = op;
            u_mem.prog_mem[base + 12'h001] = b2;
            u_mem.prog_mem[base + 12'h002] = b3;
            u_mem.data_mem[b2] = dbyte;
            {i_ret_addr, i_saved_zero, i_saved_carry, i_watchdog_sel} = {base, z, c, b3[0]};
            i_rst_n = 0;
            step(8);
            i_rst_n = 1;
            chk(o_pc, 12'h000);
            step(2);
            chk(o_pc, base);
            chk({o_zero, o_carry}, {z, c});
            i_ret_addr = ret2;
            if (kind == 5) begin
                step(3);
                chk(o_waiting, 1'b1);
                chk(o_stop, op == 8'h6D && !b3[0]);
                i_wake = 1;
                step(1);
                chk(o_waiting, 1'b0);
                i_wake = 0;
            end else begin
                step(cyc);
                chk(o_pc, exp_pc);
                chk({o_zero, o_carry}, {z, exp_c});
                chk(u_mem.data_mem[b2], exp_d);
            end
            chk(o_index_sel, op[4]);
            $display("test %0d kind %0d done", t, kind);
        end
        report_and_stop();
    end
endmodule // testbench
